// file: logic/sdram_sideband_regs.svh
// Constants for the SDRAM side-band block: offsets, fields, reset values and timing counts
`ifndef SDRAM_SIDEBAND_REGS_SVH
`define SDRAM_SIDEBAND_REGS_SVH

// ****************************************************************
// Geometry and limits
// ****************************************************************
`define NUM_CHIPS          2
`define MAX_REFRESH_BURST  4'd9
`define CFG_ADDR_W         4

// ****************************************************************
// Timing counts (cycles of clk_sys)
// ****************************************************************
`define T_REFRESH_CYC      8'd8
`define T_SR_ENTRY_CYC     8'd4
`define T_SR_EXIT_CYC      8'd10

// ****************************************************************
// Configuration word offsets and reset values
// ****************************************************************
`define CFG_OFS_CTRL       4'h0
`define CFG_OFS_TRFC       4'h1
`define CFG_OFS_TXSR       4'h2
`define CFG_OFS_ADDRW      4'h3
`define CFG_OFS_STATUS     4'h4
`define CFG_CTRL_RST       32'h0000_0001
`define CFG_ADDRW_RST      32'h0000_0D0A
`define CFG_CTRL_EN_BIT    0

`endif

// file: logic/sdram_sideband_pkg.sv
// Types shared by the SDRAM side-band modules
`default_nettype none
`include "sdram_sideband_regs.svh"
package sdram_sideband_pkg;
    typedef logic [`NUM_CHIPS-1:0] chip_mask_t;
    typedef logic [31:0]           word_t;
endpackage
`default_nettype wire

// file: logic/sideband_cfg_if.sv
// Configuration handshake between the side-band top and its config slave
`timescale 1ns/1ps
`default_nettype none
interface sideband_cfg_if;
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        rvalid;
    logic        wait_req;
    logic [7:0]  t_refresh;
    logic [7:0]  t_sr_exit;
    logic        enable;
    logic [31:0] status;
    modport master (output wr, rd, addr, wdata, status, input rdata, rvalid, wait_req, t_refresh, t_sr_exit, enable);
    modport slave  (input wr, rd, addr, wdata, status, output rdata, rvalid, wait_req, t_refresh, t_sr_exit, enable);
endinterface
`default_nettype wire

// file: logic/sideband_cfg_slave.sv
// Configuration and status word slave, on the controller clock
`timescale 1ns/1ps
`default_nettype none
`include "sdram_sideband_regs.svh"
module sideband_cfg_slave
    import sdram_sideband_pkg::*;
#(
    parameter bit ENABLE = 1'b1
) (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    // Register side
    sideband_cfg_if.slave cfg
);
    // ****************************************************************
    // Stored words
    // ****************************************************************
    word_t ctrl;
    word_t trfc;
    word_t txsr;
    word_t addrw;
    word_t rdata;
    logic  rvalid;

    // Read selection; unmapped offsets read zero
    wire word_t sel_rdata =
        (cfg.addr == `CFG_OFS_CTRL)   ? ctrl  :
        (cfg.addr == `CFG_OFS_TRFC)   ? trfc  :
        (cfg.addr == `CFG_OFS_TXSR)   ? txsr  :
        (cfg.addr == `CFG_OFS_ADDRW)  ? addrw :
        (cfg.addr == `CFG_OFS_STATUS) ? cfg.status : 32'h0000_0000;

    generate
        if (ENABLE) begin : g_on
            // Writes take effect while the controller runs, same clock, no crossing
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl  <= `CFG_CTRL_RST;
                    trfc  <= {24'h00_0000, `T_REFRESH_CYC};
                    txsr  <= {24'h00_0000, `T_SR_EXIT_CYC};
                    addrw <= `CFG_ADDRW_RST;
                end else if (cfg.wr) begin
                    if (cfg.addr == `CFG_OFS_CTRL)  ctrl  <= cfg.wdata;
                    if (cfg.addr == `CFG_OFS_TRFC)  trfc  <= cfg.wdata;
                    if (cfg.addr == `CFG_OFS_TXSR)  txsr  <= cfg.wdata;
                    if (cfg.addr == `CFG_OFS_ADDRW) addrw <= cfg.wdata;
                end
            end
            // One-cycle read latency
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    rdata  <= 32'h0000_0000;
                    rvalid <= 1'b0;
                end else begin
                    rdata  <= cfg.rd ? sel_rdata : 32'h0000_0000;
                    rvalid <= cfg.rd;
                end
            end
        end else begin : g_off
            // Removed: constants only, no flops left
            assign ctrl   = `CFG_CTRL_RST;
            assign trfc   = {24'h00_0000, `T_REFRESH_CYC};
            assign txsr   = {24'h00_0000, `T_SR_EXIT_CYC};
            assign addrw  = `CFG_ADDRW_RST;
            assign rdata  = 32'h0000_0000;
            assign rvalid = 1'b0;
        end
    endgenerate

    // Outputs to the block; a zero count is clamped to one cycle
    assign cfg.rdata     = rdata;
    assign cfg.rvalid    = rvalid;
    assign cfg.wait_req  = 1'b0;
    assign cfg.t_refresh = (trfc[7:0] == 8'h00) ? 8'h01 : trfc[7:0];
    assign cfg.t_sr_exit = (txsr[7:0] == 8'h00) ? 8'h01 : txsr[7:0];
    assign cfg.enable    = ctrl[`CFG_CTRL_EN_BIT];
endmodule
`default_nettype wire

// file: logic/sdram_refresh_sideband.sv
// Self-refresh and user refresh side-band sequencer with configuration port
`timescale 1ns/1ps
`default_nettype none
`include "sdram_sideband_regs.svh"
module sdram_refresh_sideband
    import sdram_sideband_pkg::*;
#(
    parameter bit CFG_ENABLE = 1'b1
) (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    // Low-power interface
    input  wire logic                   lp_req,
    output logic                        lp_ack,
    // User refresh interface
    input  wire logic                   ref_req,
    input  wire logic [`NUM_CHIPS-1:0]  ref_chip,
    output logic                        ref_ack,
    // Command queue arbitration
    input  wire logic                   queue_cmd_valid,
    output logic                        queue_cmd_grant,
    // Memory command strobes
    output logic                        mem_refresh,
    output logic                        mem_sr_enter,
    output logic                        mem_sr_exit,
    output logic [`NUM_CHIPS-1:0]       mem_chip,
    output logic [`NUM_CHIPS-1:0]       mem_in_sr,
    // Configuration port
    input  wire logic                   cfg_write,
    input  wire logic                   cfg_read,
    input  wire logic [`CFG_ADDR_W-1:0] cfg_address,
    input  wire logic [31:0]            cfg_writedata,
    output logic [31:0]                 cfg_readdata,
    output logic                        cfg_readdatavalid,
    output logic                        cfg_waitrequest
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_sync;
    logic       rst_n;
    // Two flops so release is clean to the clock
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) rst_sync <= 2'b00;
        else          rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ****************************************************************
    // Configuration slave
    // ****************************************************************
    sideband_cfg_if cfg ();
    assign cfg.wr     = cfg_write;
    assign cfg.rd     = cfg_read;
    assign cfg.addr   = cfg_address;
    assign cfg.wdata  = cfg_writedata;
    sideband_cfg_slave #(.ENABLE(CFG_ENABLE)) u_cfg (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .cfg     (cfg)
    );
    assign cfg_readdata      = cfg.rdata;
    assign cfg_readdatavalid = cfg.rvalid;
    assign cfg_waitrequest   = cfg.wait_req;

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    typedef enum logic [2:0] {ST_IDLE, ST_REFRESH, ST_SR_ENTER, ST_IN_SR, ST_SR_EXIT} seq_e;
    seq_e        state;
    seq_e        next_state;
    logic [7:0]  timer;
    logic [7:0]  next_timer;
    logic [3:0]  burst;
    logic [3:0]  next_burst;
    chip_mask_t  sr_chips;
    chip_mask_t  next_sr_chips;
    chip_mask_t  cmd_chip;
    chip_mask_t  next_cmd_chip;
    logic        lp_ack_q;
    logic        next_lp_ack;

    // True when two chip masks name no chip in common
    function automatic logic chips_apart(input chip_mask_t a, input chip_mask_t b);
        return (a & b) == '0;
    endfunction

    // Decoded conditions; refresh may run beside self-refresh of the other chips
    wire logic       timer_done = (timer == 8'h01);
    wire logic       ref_ok     = ref_req && (ref_chip != '0) && chips_apart(ref_chip, sr_chips);
    wire logic       burst_full = (burst >= `MAX_REFRESH_BURST);
    wire logic       start_ref  = ref_ok && !burst_full && cfg.enable;
    wire logic       ref_slot   = (state == ST_IDLE) || (state == ST_IN_SR);
    wire logic       issue_ref  = ref_slot && start_ref;
    wire chip_mask_t sr_target  = ~ref_chip;
    // An entry naming no chip waits, so lp_ack never rises over an empty mask
    wire logic       sr_go      = lp_req && cfg.enable && (sr_target != '0);

    // Next-state decode; refresh checked before self-refresh entry
    always_comb begin
        next_state    = state;
        next_timer    = (timer != 8'h00) ? timer - 8'h01 : 8'h00;
        next_burst    = burst;
        next_sr_chips = sr_chips;
        next_cmd_chip = cmd_chip;
        next_lp_ack   = lp_ack_q;
        // A dropped request ends the run of back-to-back refreshes in any state
        if (!ref_req) next_burst = 4'h0;
        unique case (state)
            ST_IDLE: begin
                if (start_ref) begin
                    next_state    = ST_REFRESH;
                    next_timer    = cfg.t_refresh;
                    next_cmd_chip = ref_chip;
                    next_burst    = burst + 4'h1;
                end else if (sr_go) begin
                    next_state    = ST_SR_ENTER;
                    next_timer    = `T_SR_ENTRY_CYC;
                    next_cmd_chip = sr_target;
                end
            end
            ST_REFRESH: begin
                // Back to self-refresh while the other chips still sleep
                if (timer_done && (sr_chips != '0)) begin
                    next_state = ST_IN_SR;
                end else if (timer_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_SR_ENTER: begin
                if (timer_done) begin
                    next_state    = ST_IN_SR;
                    next_sr_chips = cmd_chip;
                    next_lp_ack   = 1'b1;
                end
            end
            ST_IN_SR: begin
                // Refresh of the chips left awake goes first
                if (start_ref) begin
                    next_state    = ST_REFRESH;
                    next_timer    = cfg.t_refresh;
                    next_cmd_chip = ref_chip;
                    next_burst    = burst + 4'h1;
                end else if (!lp_req) begin
                    next_state = ST_SR_EXIT;
                    next_timer = cfg.t_sr_exit;
                end
            end
            ST_SR_EXIT: begin
                if (timer_done) begin
                    next_state    = ST_IDLE;
                    next_sr_chips = '0;
                    next_lp_ack   = 1'b0;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            timer    <= 8'h00;
            burst    <= 4'h0;
            sr_chips <= '0;
            cmd_chip <= '0;
            lp_ack_q <= 1'b0;
        end else begin
            state    <= next_state;
            timer    <= next_timer;
            burst    <= next_burst;
            sr_chips <= next_sr_chips;
            cmd_chip <= next_cmd_chip;
            lp_ack_q <= next_lp_ack;
        end
    end

    // ****************************************************************
    // Command strobes and acknowledges
    // ****************************************************************
    logic ref_ack_q;
    logic ref_cmd_q;
    logic sr_enter_q;
    logic sr_exit_q;
    chip_mask_t mem_chip_q;
    // Registered one-cycle strobes, one per command
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_ack_q  <= 1'b0;
            ref_cmd_q  <= 1'b0;
            sr_enter_q <= 1'b0;
            sr_exit_q  <= 1'b0;
            mem_chip_q <= '0;
        end else begin
            ref_ack_q  <= issue_ref;
            ref_cmd_q  <= issue_ref;
            sr_enter_q <= (state == ST_IDLE) && !start_ref && sr_go;
            sr_exit_q  <= (state == ST_IN_SR) && !start_ref && !lp_req;
            mem_chip_q <= next_cmd_chip;
        end
    end

    // Queued reads and writes only pass in ST_IDLE when no refresh starts that cycle
    assign queue_cmd_grant = queue_cmd_valid && (state == ST_IDLE) && !start_ref;
    assign cfg.status      = {24'h00_0000, 2'b00, burst, lp_ack_q, (state != ST_IDLE)};
    assign lp_ack          = lp_ack_q;
    assign ref_ack         = ref_ack_q;
    assign mem_refresh     = ref_cmd_q;
    assign mem_sr_enter    = sr_enter_q;
    assign mem_sr_exit     = sr_exit_q;
    assign mem_chip        = mem_chip_q;
    assign mem_in_sr       = sr_chips;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_ack_pulse;
        @(posedge clk_sys) disable iff (!rst_n) ref_ack |=> !ref_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("refresh ack longer than one cycle");

    property p_ack_with_cmd;
        @(posedge clk_sys) disable iff (!rst_n) ref_ack |-> mem_refresh && (mem_chip != '0);
    endproperty
    a_ack_with_cmd: assert property (p_ack_with_cmd) else $error("ack without refresh command");

    property p_no_overlap;
        @(posedge clk_sys) disable iff (!rst_n) mem_refresh |-> chips_apart(mem_chip, mem_in_sr);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("refresh hits chip in self-refresh");

    property p_burst_cap;
        @(posedge clk_sys) disable iff (!rst_n) burst <= 4'd9;
    endproperty
    a_burst_cap: assert property (p_burst_cap) else $error("more than nine refreshes back to back");

    property p_grant_blocked;
        @(posedge clk_sys) disable iff (!rst_n) (state == ST_IDLE && start_ref) |-> !queue_cmd_grant;
    endproperty
    a_grant_blocked: assert property (p_grant_blocked) else $error("queue granted over refresh");

    property p_lp_ack_after_sr;
        @(posedge clk_sys) disable iff (!rst_n) $rose(lp_ack) |-> (mem_in_sr != '0) && $past(state) == ST_SR_ENTER;
    endproperty
    a_lp_ack_after_sr: assert property (p_lp_ack_after_sr) else $error("lp ack before self-refresh");

    property p_lp_ack_holds;
        @(posedge clk_sys) disable iff (!rst_n) $fell(lp_ack) |-> $past(state) == ST_SR_EXIT && mem_in_sr == '0;
    endproperty
    a_lp_ack_holds: assert property (p_lp_ack_holds) else $error("lp ack fell before exit");

    property p_exit_follows;
        @(posedge clk_sys) disable iff (!rst_n)
            (lp_ack && !lp_req && !start_ref && state == ST_IN_SR) |=> ##[0:256] !lp_ack;
    endproperty
    a_exit_follows: assert property (p_exit_follows) else $error("self-refresh exit too slow");

    property p_any_chip;
        @(posedge clk_sys) disable iff (!rst_n) lp_ack |-> (mem_in_sr != '0);
    endproperty
    a_any_chip: assert property (p_any_chip) else $error("lp ack with no chip in self-refresh");

    property p_sr_enter_pulse;
        @(posedge clk_sys) disable iff (!rst_n) mem_sr_enter |=> !mem_sr_enter;
    endproperty
    a_sr_enter_pulse: assert property (p_sr_enter_pulse) else $error("entry strobe too long");

    property p_burst_clear;
        @(posedge clk_sys) disable iff (!rst_n) !ref_req |=> burst == 4'h0;
    endproperty
    a_burst_clear: assert property (p_burst_clear) else $error("burst kept after request fell");

    property p_exit_cmd;
        @(posedge clk_sys) disable iff (!rst_n) mem_sr_exit |-> (state == ST_SR_EXIT) && lp_ack;
    endproperty
    a_exit_cmd: assert property (p_exit_cmd) else $error("exit command without held ack");

    property p_ref_chip;
        @(posedge clk_sys) disable iff (!rst_n) ref_ack |-> mem_chip == $past(ref_chip);
    endproperty
    a_ref_chip: assert property (p_ref_chip) else $error("refresh sent to wrong chip");

    // Main scenarios, refresh beside self-refresh included
    c_single_ref:  cover property (@(posedge clk_sys) disable iff (!rst_n) ref_ack ##1 !ref_req);
    c_burst_nine:  cover property (@(posedge clk_sys) disable iff (!rst_n) burst == 4'd9);
    c_lp_cycle:    cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(lp_ack) ##[1:300] $fell(lp_ack));
    c_ref_over_q:  cover property (@(posedge clk_sys) disable iff (!rst_n) queue_cmd_valid && issue_ref);
    c_ref_in_sr:   cover property (@(posedge clk_sys) disable iff (!rst_n) mem_refresh && (mem_in_sr != '0));
endmodule
`default_nettype wire

// file: tb/refresh_requester_model.sv
// Requester model: user logic raising refresh requests and counting acknowledges
`timescale 1ns/1ps
`default_nettype none
module refresh_requester_model
    import sdram_sideband_pkg::*;
(
    // Clock
    input  wire logic       clk_sys,
    // Commands from the bench
    input  wire logic       go,
    input  wire logic [3:0] n_req,
    input  wire chip_mask_t chip_sel,
    // Refresh interface
    output logic            ref_req,
    output chip_mask_t      ref_chip,
    input  wire logic       ref_ack,
    // Status to the bench
    output logic            busy,
    output int              acks
);
    int idle_cnt;

    initial begin
        ref_req = 1'b0;
        busy = 1'b0;
        acks = 0;
        idle_cnt = 0;
    end

    // Chip select held steady whenever a request may be up
    assign ref_chip = chip_sel;

    // Hold the request until enough acks, or give up once the device stops answering
    always @(posedge clk_sys) begin
        if (go && !busy) begin
            busy <= 1'b1;
            ref_req <= 1'b1;
            acks <= 0;
            idle_cnt <= 0;
        end else if (busy) begin
            idle_cnt <= ref_ack ? 0 : idle_cnt + 1;
            if (ref_ack) begin
                acks <= acks + 1;
            end
            if ((ref_ack && acks + 1 >= int'(n_req)) || idle_cnt > 40) begin
                ref_req <= 1'b0;
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/sdram_refresh_sideband_tb_top.sv
// Self-checking bench for the refresh and low-power side-band block
`timescale 1ns/1ps
`default_nettype none
`include "sdram_sideband_regs.svh"
module sdram_refresh_sideband_tb_top;
    import sdram_sideband_pkg::*;
    logic clk_sys, reset_n, lp_req, lp_ack, ref_req, ref_ack, qv, grant, go, busy;
    logic mem_refresh, cfg_write, cfg_read, rdv, wreq, prev_ack, sre, srx, prev_qv, prev_grant;
    chip_mask_t ref_chip, mem_chip, mem_in_sr, chip_sel;
    logic [3:0] cfg_address, n_req;
    word_t wdata, rdata, d;
    int error_cnt, samples_checked, acks, cyc, k, sp8, sp3, n_sre, n_srx;
    int ack_t[$];
    int nlist[6] = '{1, 9, 12, 0, 0, 0};
    logic [3:0] addrs[6] = '{`CFG_OFS_CTRL, `CFG_OFS_TRFC, `CFG_OFS_TXSR, `CFG_OFS_ADDRW, `CFG_OFS_STATUS, 4'hF};
    word_t exps[6] = '{`CFG_CTRL_RST, 32'h0000_0008, 32'h0000_000A, `CFG_ADDRW_RST, 32'h0, 32'h0};

    sdram_refresh_sideband u_sdram_refresh_sideband (
        .clk_sys(clk_sys), .reset_n(reset_n), .lp_req(lp_req), .lp_ack(lp_ack),
        .ref_req(ref_req), .ref_chip(ref_chip), .ref_ack(ref_ack),
        .queue_cmd_valid(qv), .queue_cmd_grant(grant), .mem_refresh(mem_refresh),
        .mem_sr_enter(sre), .mem_sr_exit(srx), .mem_chip(mem_chip), .mem_in_sr(mem_in_sr),
        .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_address(cfg_address),
        .cfg_writedata(wdata), .cfg_readdata(rdata), .cfg_readdatavalid(rdv),
        .cfg_waitrequest(wreq));
    refresh_requester_model u_refresh_requester_model (
        .clk_sys(clk_sys), .go(go), .n_req(n_req), .chip_sel(chip_sel), .ref_req(ref_req),
        .ref_chip(ref_chip), .ref_ack(ref_ack), .busy(busy), .acks(acks));

    // Clock, 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************
    // Per-cycle monitor and random queue traffic
    // ****************************************
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        prev_ack <= ref_ack;
        prev_qv <= qv;
        prev_grant <= grant;
        qv <= 1'($urandom);
        if (reset_n) begin
            if (ref_ack) ack_t.push_back(cyc);
            if (sre) n_sre <= n_sre + 1;
            if (srx) n_srx <= n_srx + 1;
            if (ref_ack && prev_qv) check(prev_grant, 0, "grant at refresh issue");
            check(mem_refresh, ref_ack, "refresh strobe");
            if (ref_ack) check(prev_ack, 0, "ack longer than a cycle");
            if (ref_ack && qv) check(grant, 0, "grant during refresh");
        end
    end

    task automatic cfg_wr(input logic [3:0] a, input word_t v);
        @(posedge clk_sys);
        cfg_write <= 1'b1;
        cfg_address <= a;
        wdata <= v;
        @(posedge clk_sys);
        cfg_write <= 1'b0;
    endtask

    task automatic cfg_rd(input logic [3:0] a, output word_t v);
        @(posedge clk_sys);
        cfg_read <= 1'b1;
        cfg_address <= a;
        @(posedge clk_sys);
        cfg_read <= 1'b0;
        #1;
        check(rdv, 1, "read valid");
        check(wreq, 0, "wait request");
        v = rdata;
    endtask

    // Burst of n refreshes; expected count is capped at nine
    task automatic burst(input int n, input chip_mask_t c, output int sp);
        ack_t.delete();
        @(posedge clk_sys);
        chip_sel <= c;
        n_req <= 4'(n);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (int i = 0; i < 600; i++) begin
            @(posedge clk_sys);
            #1;
            if (!busy && i > 2) break;
        end
        check(acks, (n > 9) ? 9 : n, "refresh count");
        sp = (ack_t.size() > 1) ? ack_t[1] - ack_t[0] : 0;
    endtask

    // Edges until lp_ack reaches the wanted level
    task automatic lp_wait(input logic lvl, output int n);
        n = 0;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (lp_ack === lvl) break;
        end
    endtask

    // Watchdog
    initial begin
        #(50 * 20000);
        error_cnt++;
        final_report();
    end

    // Main sequence
    initial begin
        word_t rv;
        int s;
        {reset_n, lp_req, qv, go, cfg_write, cfg_read, prev_ack, prev_qv, prev_grant} = '0;
        {cfg_address, n_req, wdata, chip_sel, cyc, n_sre, n_srx} = '0;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(32'h54830915));
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 6; i++) begin
            cfg_rd(addrs[i], d);
            check(d, exps[i], "reset value");
        end
        for (int i = 3; i < 6; i++) nlist[i] = 1 + $urandom % 12;
        foreach (nlist[i]) begin
            burst(nlist[i], chip_mask_t'(1 + $urandom % 3), s);
            if (nlist[i] > 1) sp8 = s;
        end
        // Shorter refresh time must shorten the spacing by the same amount
        cfg_wr(`CFG_OFS_TRFC, 32'h3);
        cfg_rd(`CFG_OFS_TRFC, d);
        check(d, 32'h3, "trfc readback");
        burst(3, 2'b11, sp3);
        check(sp8 - sp3, 5, "refresh spacing");
        cfg_wr(`CFG_OFS_TRFC, 32'h8);
        rv = $urandom & 32'hFFFF;
        cfg_wr(`CFG_OFS_ADDRW, rv);
        cfg_wr(4'hF, 32'hFFFF_FFFF);
        cfg_rd(`CFG_OFS_ADDRW, d);
        check(d, rv, "address width");
        cfg_rd(4'hF, d);
        check(d, 0, "unmapped");
        // Self-refresh of the chip not selected, user refresh of the other meanwhile
        chip_sel <= 2'b01;
        @(posedge clk_sys);
        lp_req <= 1'b1;
        lp_wait(1'b1, k);
        check(k, `T_SR_ENTRY_CYC + 1, "entry latency");
        check(mem_in_sr, 2'b10, "chips in self-refresh");
        cfg_rd(`CFG_OFS_STATUS, d);
        check(d[1], 1, "status ack bit");
        burst(2, 2'b01, s);
        check(lp_ack, 1, "ack held");
        // Let the last refresh run out so the exit count starts clean
        repeat (12) @(posedge clk_sys);
        lp_req <= 1'b0;
        lp_wait(1'b0, k);
        check(k, `T_SR_EXIT_CYC + 1, "exit latency");
        check(mem_in_sr, 0, "chips left self-refresh");
        check(n_sre, 1, "entry commands");
        check(n_srx, 1, "exit commands");
        repeat (4) @(posedge clk_sys);
        final_report();
    end
endmodule
`default_nettype wire
